//--- cms_pkg.sv
`default_nettype none
package cms_pkg;
   // word indices; byte address is four times the index
   localparam logic [5:0] CMS_IDX_GEN_STATUS = 6'h00;
   localparam logic [5:0] CMS_IDX_CFG_ERR = 6'h02;
   localparam logic [5:0] CMS_IDX_MEM_STATUS = 6'h13;
   localparam logic [5:0] CMS_IDX_IRQ_STATUS = 6'h20;
   localparam logic [5:0] CMS_IDX_IRQ_MASK = 6'h21;
   localparam logic [5:0] CMS_IDX_CONTROL = 6'h22;

   localparam int CMS_ADR_W = 8;
   localparam int CMS_WORD_W = 16;

   // general status word
   localparam int CMS_GEN_CFG_ERR_BIT = 1;
   // configuration error word
   localparam int CMS_CFG_ARRANGE_BIT = 8;
   // memory and write mode status word
   localparam int CMS_MEM_SAVE_ERR_BIT = 1;
   localparam int CMS_MEM_REG_ERR_BIT = 3;
   localparam int CMS_MEM_WMODE_BIT = 8;
   localparam int CMS_MEM_DIRTY_BIT = 9;

   // control word
   localparam int CMS_CTL_WMODE_BIT = 0;
   localparam int CMS_CTL_STORE_BIT = 1;
   localparam logic [1:0] CMS_CTL_RESET = 2'h0;

   // interrupt event bits, same layout in status and mask
   localparam int CMS_EV_COUNT = 4;
   localparam int CMS_EV_ARRANGE = 0;
   localparam int CMS_EV_SAVE = 1;
   localparam int CMS_EV_REG = 2;
   localparam int CMS_EV_DIRTY = 3;
   localparam logic [3:0] CMS_IRQ_RESET = 4'h0;

   typedef enum logic {CMS_WMODE_BACKUP, CMS_WMODE_RAM_ONLY} cms_wmode_t;
endpackage
`default_nettype wire

//--- cms_dirty_track.sv
`default_nettype none
module cms_dirty_track
   import cms_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire cms_pkg::cms_wmode_t wmode,
   input wire logic setting_write,
   input wire logic nv_store_done,
   output logic dirty
);
   import cms_pkg::*;

   logic dirty_q;
   logic dirty_d;
   logic set_dirty;

   // in backup mode every write also lands in nonvolatile memory, so no gap opens
   assign set_dirty = setting_write && (wmode == CMS_WMODE_RAM_ONLY);
   // a write in the same cycle as a finished store leaves the copies apart
   assign dirty_d = set_dirty ? 1'b1 : (nv_store_done ? 1'b0 : dirty_q);
   assign dirty = dirty_q;

   always_ff @(posedge clk)
   begin
      if (rst)
         dirty_q <= 1'b0;
      else
         dirty_q <= dirty_d;
   end
endmodule // cms_dirty_track
`default_nettype wire

//--- cms_status_regs.sv
// Behaviour
// - arrangement flag set while unit left of head
// - report interrupted secondary RAM save
// - report interrupted configuration registration
// - write mode bit: backup or RAM only
// - consistency bit: one while RAM differs
// - memory status word at index 13h
// - general status summarises configuration errors
`default_nettype none
module cms_status_regs
   import cms_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [cms_pkg::CMS_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic unit_left_of_head,
   input wire logic secondary_ram_area_save_aborted,
   input wire logic registration_aborted,
   input wire logic setting_write,
   input wire logic nv_store_done,
   output logic nv_store_req,
   output logic backup_write_en,
   output logic irq
);
   import cms_pkg::*;

   function automatic logic reg_hit(input logic [CMS_ADR_W-1:0] adr, input logic [5:0] idx);
      reg_hit = (adr[CMS_ADR_W-1:2] == idx) && (adr[1:0] == 2'h0);
   endfunction

   // bus handshake
   logic access;
   logic wr_stb;
   logic rd_stb;
   logic ack_q;
   logic [31:0] dat_q;
   logic [31:0] dat_d;

   // the ack cycle is not taken again, so a held request is served every other cycle
   assign access = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_stb = access && wb_we_i;
   assign rd_stb = access && !wb_we_i;

   // address decode
   // the two low address bits must be zero, else the access counts as unmapped
   wire hit_gen = reg_hit(wb_adr_i, CMS_IDX_GEN_STATUS);
   wire hit_cfg = reg_hit(wb_adr_i, CMS_IDX_CFG_ERR);
   wire hit_mem = reg_hit(wb_adr_i, CMS_IDX_MEM_STATUS);
   wire hit_ists = reg_hit(wb_adr_i, CMS_IDX_IRQ_STATUS);
   wire hit_imsk = reg_hit(wb_adr_i, CMS_IDX_IRQ_MASK);
   wire hit_ctl = reg_hit(wb_adr_i, CMS_IDX_CONTROL);
   wire lane0 = wb_sel_i[0];

   // sampled status inputs
   logic arrange_q;
   logic save_err_q;
   logic reg_err_q;
   logic arrange_prev_q;
   logic save_prev_q;
   logic reg_prev_q;
   logic dirty_prev_q;
   logic dirty;

   // error flags follow their inputs; the power-loss record itself is kept outside
   always_ff @(posedge clk)
   begin
      if (rst)
         arrange_q <= 1'b0;
      else
         arrange_q <= unit_left_of_head;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         save_err_q <= 1'b0;
      else
         save_err_q <= secondary_ram_area_save_aborted;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         reg_err_q <= 1'b0;
      else
         reg_err_q <= registration_aborted;
   end

   // previous levels for the rising-edge events; cleared so that a level held
   // through reset still shows up as one event after release
   always_ff @(posedge clk)
   begin
      if (rst)
         arrange_prev_q <= 1'b0;
      else
         arrange_prev_q <= arrange_q;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         save_prev_q <= 1'b0;
      else
         save_prev_q <= save_err_q;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         reg_prev_q <= 1'b0;
      else
         reg_prev_q <= reg_err_q;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         dirty_prev_q <= 1'b0;
      else
         dirty_prev_q <= dirty;
   end

   // control word: write mode and a one-shot store command
   logic [1:0] ctl_q;
   logic [1:0] ctl_d;
   logic store_req_q;
   logic ctl_wr;
   cms_wmode_t wmode;

   assign ctl_wr = wr_stb && hit_ctl && lane0;
   assign ctl_d = ctl_wr ? wb_dat_i[1:0] : ctl_q;
   assign wmode = ctl_q[CMS_CTL_WMODE_BIT] ? CMS_WMODE_RAM_ONLY : CMS_WMODE_BACKUP;

   // store bit never stays set, so each write asks for one store only
   always_ff @(posedge clk)
   begin
      if (rst)
         ctl_q <= CMS_CTL_RESET;
      else
         ctl_q <= {1'b0, ctl_d[CMS_CTL_WMODE_BIT]};
   end

   // a mode change leaves the consistency bit alone; only a finished store clears it
   always_ff @(posedge clk)
   begin
      if (rst)
         store_req_q <= 1'b0;
      else
         store_req_q <= ctl_wr && wb_dat_i[CMS_CTL_STORE_BIT];
   end

   assign nv_store_req = store_req_q;
   assign backup_write_en = (wmode == CMS_WMODE_BACKUP);

   // consistency is tracked apart so that its set and clear rules stay in one place
   cms_dirty_track u_dirty
   (
      .clk(clk),
      .rst(rst),
      .wmode(wmode),
      .setting_write(setting_write),
      .nv_store_done(nv_store_done),
      .dirty(dirty)
   );

   // status word images; unused bits are tied low
   logic [CMS_WORD_W-1:0] cfg_word;
   logic [CMS_WORD_W-1:0] mem_word;
   logic [CMS_WORD_W-1:0] gen_word;

   always_comb
   begin
      cfg_word = '0;
      cfg_word[CMS_CFG_ARRANGE_BIT] = arrange_q;
   end

   always_comb
   begin
      mem_word = '0;
      // bits 8 and 9 come from control state and the tracker, not from pins
      mem_word[CMS_MEM_SAVE_ERR_BIT] = save_err_q;
      mem_word[CMS_MEM_REG_ERR_BIT] = reg_err_q;
      mem_word[CMS_MEM_WMODE_BIT] = (wmode == CMS_WMODE_RAM_ONLY);
      mem_word[CMS_MEM_DIRTY_BIT] = dirty;
   end

   always_comb
   begin
      gen_word = '0;
      // any configuration error word bit raises the summary
      gen_word[CMS_GEN_CFG_ERR_BIT] = |cfg_word;
   end

   // interrupts: sticky events, write one to clear, mask gates the output
   logic [CMS_EV_COUNT-1:0] ev;
   logic [CMS_EV_COUNT-1:0] ists_q;
   logic [CMS_EV_COUNT-1:0] ists_d;
   logic [CMS_EV_COUNT-1:0] imsk_q;
   logic [CMS_EV_COUNT-1:0] clr;
   logic ists_wr;
   logic imsk_wr;

   // events are rising edges of the flags; a flag that stays up is counted once
   assign ev[CMS_EV_ARRANGE] = arrange_q && !arrange_prev_q;
   assign ev[CMS_EV_SAVE] = save_err_q && !save_prev_q;
   assign ev[CMS_EV_REG] = reg_err_q && !reg_prev_q;
   assign ev[CMS_EV_DIRTY] = dirty && !dirty_prev_q;

   assign ists_wr = wr_stb && hit_ists && lane0;
   assign imsk_wr = wr_stb && hit_imsk && lane0;
   assign clr = ists_wr ? wb_dat_i[CMS_EV_COUNT-1:0] : '0;

   genvar gi;
   generate
      for (gi = 0; gi < CMS_EV_COUNT; gi++)
      begin : g_ev
         // a new event in the clearing cycle keeps its bit
         assign ists_d[gi] = ev[gi] || (ists_q[gi] && !clr[gi]);
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (rst)
         ists_q <= CMS_IRQ_RESET;
      else
         ists_q <= ists_d;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         imsk_q <= CMS_IRQ_RESET;
      else if (imsk_wr)
         imsk_q <= wb_dat_i[CMS_EV_COUNT-1:0];
   end

   logic irq_q;

   // irq follows the next status, so a clear and the drop of irq share one edge
   always_ff @(posedge clk)
   begin
      if (rst)
         irq_q <= 1'b0;
      else
         irq_q <= |(ists_d & imsk_q);
   end

   assign irq = irq_q;

   // read mux; writes to the status words fall through with no effect
   wire [31:0] rd_gen = {16'h0000, gen_word};
   wire [31:0] rd_cfg = {16'h0000, cfg_word};
   wire [31:0] rd_mem = {16'h0000, mem_word};
   wire [31:0] rd_ists = {28'h0000000, ists_q};
   wire [31:0] rd_imsk = {28'h0000000, imsk_q};
   wire [31:0] rd_ctl = {30'h00000000, ctl_q};

   always_comb
   begin
      dat_d = 32'h00000000;
      if (hit_gen)
         dat_d = rd_gen;
      else if (hit_cfg)
         dat_d = rd_cfg;
      else if (hit_mem)
         dat_d = rd_mem;
      else if (hit_ists)
         dat_d = rd_ists;
      else if (hit_imsk)
         dat_d = rd_imsk;
      else if (hit_ctl)
         dat_d = rd_ctl;
   end

   // every access is answered in one cycle; unmapped reads return zero
   always_ff @(posedge clk)
   begin
      if (rst)
         ack_q <= 1'b0;
      else
         ack_q <= access;
   end

   // read data holds until the next read, so a late sample still sees the word
   always_ff @(posedge clk)
   begin
      if (rst)
         dat_q <= 32'h00000000;
      else if (rd_stb)
         dat_q <= dat_d;
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
endmodule // cms_status_regs
`default_nettype wire

//--- cms_nv_model.sv
`default_nettype none
module cms_nv_model
#(
   parameter int DLY = 3
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic nv_store_req,
   output logic nv_store_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DLY-1:0] sh_q;
   // nonvolatile copy catches up DLY cycles after a store request
   always_ff @(posedge clk)
      sh_q <= rst ? '0 : {sh_q[DLY-2:0], nv_store_req};
   assign nv_store_done = sh_q[DLY-1];
endmodule // cms_nv_model
`default_nettype wire

//--- cms_status_regs_sva.sv
`default_nettype none
module cms_status_regs_chk
   import cms_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [cms_pkg::CMS_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic unit_left_of_head,
   input wire logic secondary_ram_area_save_aborted,
   input wire logic registration_aborted,
   input wire logic setting_write,
   input wire logic nv_store_done,
   input wire logic nv_store_req,
   input wire logic backup_write_en,
   input wire logic irq
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_rd(logic [7:0] a);
      wb_ack_o && $past(!wb_we_i && wb_adr_i == a);
   endsequence
   a_ack_answer:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   a_ack_pulse:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_upper_zero:
      assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper bits set");
   a_cfg_read:
      assert property (s_rd(8'h08) |-> wb_dat_o == {23'h0, $past(unit_left_of_head, 2), 8'h0})
         else $error("bad cfg word");
   a_gen_summary:
      assert property (s_rd(8'h00) |-> wb_dat_o[1] == $past(unit_left_of_head, 2))
         else $error("bad summary");
   a_mem_errors:
      assert property (s_rd(8'h4C) |-> wb_dat_o[3:0] == {$past(registration_aborted, 2), 1'b0,
         $past(secondary_ram_area_save_aborted, 2), 1'b0}) else $error("bad error bits");
   a_mode_read:
      assert property (s_rd(8'h4C) |-> wb_dat_o[8] == !$past(backup_write_en))
         else $error("bad mode bit");
   a_store_cause:
      assert property (wb_ack_o && $past(wb_we_i && wb_adr_i == 8'h88 && wb_sel_i[0]
         && wb_dat_i[1]) |-> nv_store_req) else $error("no store request");
   c_store: cover property (nv_store_req);
   c_irq: cover property ($rose(irq));
   c_cfg: cover property (s_rd(8'h08) ##0 wb_dat_o[8]);
endmodule // cms_status_regs_chk
bind cms_status_regs cms_status_regs_chk u_chk
(
   .clk(clk),
   .rst(rst),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .unit_left_of_head(unit_left_of_head),
   .secondary_ram_area_save_aborted(secondary_ram_area_save_aborted),
   .registration_aborted(registration_aborted),
   .setting_write(setting_write),
   .nv_store_done(nv_store_done),
   .nv_store_req(nv_store_req),
   .backup_write_en(backup_write_en),
   .irq(irq)
);
`default_nettype wire

//--- tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, irq;
   logic unit_left_of_head = 0, secondary_ram_area_save_aborted = 0, registration_aborted = 0;
   logic setting_write = 0, nv_store_done, nv_store_req, backup_write_en;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   int n_errors = 0, comparisons = 0;
   always #20 clk = ~clk;
   cms_status_regs DUT
   (
      .clk(clk),
      .rst(rst),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .unit_left_of_head(unit_left_of_head),
      .secondary_ram_area_save_aborted(secondary_ram_area_save_aborted),
      .registration_aborted(registration_aborted),
      .setting_write(setting_write),
      .nv_store_done(nv_store_done),
      .nv_store_req(nv_store_req),
      .backup_write_en(backup_write_en),
      .irq(irq)
   );
   cms_nv_model u_nv
   (
      .clk(clk),
      .rst(rst),
      .nv_store_req(nv_store_req),
      .nv_store_done(nv_store_done)
   );
   task automatic chk(input string n, input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", n, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk iff wb_ack_o);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("rd %h", a), q, e);
   endtask
   task automatic pulse();
      @(posedge clk);
      setting_write <= 1'b1;
      @(posedge clk);
      setting_write <= 1'b0;
   endtask
   task automatic t_arrange();
      @(posedge clk);
      unit_left_of_head <= 1'b1;
      rd(8'h08, 32'h100);
      rd(8'h00, 32'h2);
      bus(1'b1, 8'h08, 32'hFFFF);
      bus(1'b1, 8'h4C, 32'hFFFF);
      rd(8'h08, 32'h100);
      rd(8'h4C, 32'h0);
      rd(8'h09, 32'h0);
      unit_left_of_head <= 1'b0;
      rd(8'h08, 32'h0);
   endtask
   task automatic t_errors();
      secondary_ram_area_save_aborted <= 1'b1;
      rd(8'h4C, 32'h2);
      registration_aborted <= 1'b1;
      rd(8'h4C, 32'hA);
      secondary_ram_area_save_aborted <= 1'b0;
      registration_aborted <= 1'b0;
      rd(8'h4C, 32'h0);
      rd(8'h80, 32'h7);
   endtask
   task automatic t_mode();
      bus(1'b1, 8'h88, 32'h1);
      rd(8'h4C, 32'h100);
      chk("bwe", {31'h0, backup_write_en}, 32'h0);
      pulse();
      rd(8'h4C, 32'h300);
      rd(8'h80, 32'hF);
      bus(1'b1, 8'h88, 32'h3);
      @(posedge clk iff nv_store_done);
      rd(8'h4C, 32'h100);
      bus(1'b1, 8'h88, 32'h0);
      pulse();
      rd(8'h4C, 32'h0);
   endtask
   task automatic t_reset();
      bus(1'b1, 8'h88, 32'h1);
      bus(1'b1, 8'h84, 32'hF);
      @(posedge clk);
      chk("irq set", {31'h0, irq}, 32'h1);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk("irq rst", {31'h0, irq}, 32'h0);
      chk("bwe rst", {31'h0, backup_write_en}, 32'h1);
      rd(8'h4C, 32'h0);
      rd(8'h88, 32'h0);
      rd(8'h80, 32'h0);
   endtask
   task automatic t_irq();
      bus(1'b1, 8'h80, 32'hF);
      rd(8'h80, 32'h0);
      unit_left_of_head <= 1'b1;
      repeat (3) @(posedge clk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      rd(8'h80, 32'h1);
      bus(1'b1, 8'h84, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, irq}, 32'h1);
      bus(1'b1, 8'h80, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq clr", {31'h0, irq}, 32'h0);
      rd(8'h80, 32'h0);
      unit_left_of_head <= 1'b0;
   endtask
   task automatic results();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(8'h4C, 32'h0);
      chk("bwe", {31'h0, backup_write_en}, 32'h1);
      t_arrange();
      t_errors();
      t_mode();
      t_reset();
      t_irq();
      results();
   end
   initial
   begin
      #100000;
      n_errors++;
      results();
   end
endmodule // tb_top
`default_nettype wire
